// ---- design/exec_subset_pkg.sv ----
package exec_subset_pkg;

    // widths and depths
    localparam int WORD_W      = 32;
    localparam int FILE_AW     = 7;
    localparam int FILE_DEPTH  = 128;
    localparam int STACK_AW    = 3;
    localparam int STACK_DEPTH = 8;
    localparam int PCHIGH_W    = 5;
    localparam int WORD_LSB    = 2;

    typedef logic [WORD_W-1:0]   word_t;
    typedef logic [7:0]          byte_t;
    typedef logic [12:0]         pc_t;
    typedef logic [13:0]         instr_t;
    typedef logic [FILE_AW-1:0]  faddr_t;
    typedef logic [STACK_AW-1:0] sptr_t;

    // register byte offsets
    localparam word_t OFF_INSTR    = 32'h0000_0000;
    localparam word_t OFF_ACC      = 32'h0000_0004;
    localparam word_t OFF_STATUS   = 32'h0000_0008;
    localparam word_t OFF_PC       = 32'h0000_000C;
    localparam word_t OFF_PC_HIGH  = 32'h0000_0010;
    localparam word_t OFF_WATCHDOG = 32'h0000_0014;
    localparam word_t OFF_STACK    = 32'h0000_0018;
    localparam word_t FILE_BASE    = 32'h0000_0200;

    // status byte bit positions
    localparam int SB_ZERO      = 2;
    localparam int SB_POWERDOWN = 3;
    localparam int SB_TIMEOUT   = 4;
    localparam int SB_SKIP      = 6;
    localparam int SB_BUSY      = 7;

    // upper program counter bits come from these latch bits
    localparam int PCHIGH_HI = 4;
    localparam int PCHIGH_LO = 3;

    // opcode fields
    localparam logic [5:0] OPC6_AND_LIT  = 6'h39;
    localparam logic [5:0] OPC6_AND_FILE = 6'h05;
    localparam logic [5:0] OPC6_COMPL    = 6'h09;
    localparam logic [3:0] OPC4_SKIP_CLR = 4'h6;
    localparam logic [3:0] OPC4_SKIP_SET = 4'h7;
    localparam logic [2:0] OPC3_CALL    = 3'h4;
    localparam instr_t     INSTR_CLR_WD = 14'h0064;

    // reset values and steps
    localparam pc_t                 PC_STEP      = 13'h0001;
    localparam pc_t                 PC_RESET     = 13'h0000;
    localparam sptr_t               SP_STEP      = 3'h1;
    localparam byte_t               BYTE_ZERO    = 8'h00;
    localparam byte_t               BYTE_STEP    = 8'h01;
    localparam byte_t               BYTE_ONES    = 8'hFF;
    localparam logic [PCHIGH_W-1:0] PCHIGH_RESET = 5'h00;
    localparam logic                FLAG_RESET   = 1'b1;

    // ahb-lite
    localparam int   HTRANS_ACT_BIT = 1;
    localparam logic HRESP_OKAY     = 1'b0;

    typedef enum logic [1:0]
    {
        ST_IDLE  = 2'b00,
        ST_EXEC  = 2'b01,
        ST_CALL2 = 2'b10
    } exec_state_e;

    // views of one instruction word
    typedef struct packed {
        logic [5:0] opc;
        byte_t      k;
    } lit_view_s;

    typedef struct packed {
        logic [5:0] opc;
        logic       dest;
        faddr_t     faddr;
    } file_view_s;

    typedef struct packed {
        logic [3:0] opc;
        logic [2:0] bsel;
        faddr_t     faddr;
    } bit_view_s;

    typedef struct packed {
        logic [2:0]  opc;
        logic [10:0] k;
    } call_view_s;

    // decoded effect of one instruction
    typedef struct packed {
        byte_t result;
        logic  zero;
        logic  wr_acc;
        logic  wr_file;
        logic  upd_zero;
        logic  skip;
        logic  call;
        logic  clr_wd;
    } exec_res_s;

endpackage

// ---- design/exec_unit.sv ----
`timescale 1ns/10ps
module exec_unit
(
    // operands
    input  wire exec_subset_pkg::instr_t instr,
    input  wire exec_subset_pkg::byte_t  acc,
    input  wire exec_subset_pkg::byte_t  fval,
    // decoded effect
    output exec_subset_pkg::exec_res_s   res
);
    import exec_subset_pkg::*;

    lit_view_s  lit;
    file_view_s fv;
    bit_view_s  bv;
    call_view_s cv;

    // the same word seen through each operand layout
    assign lit = lit_view_s'(instr);
    assign fv  = file_view_s'(instr);
    assign bv  = bit_view_s'(instr);
    assign cv  = call_view_s'(instr);

    // decode; anything else falls through as a plain one-cycle nop
    always_comb
    begin
        res = '0;
        if (lit.opc == OPC6_AND_LIT)
        begin
            res.result   = acc & lit.k;
            res.wr_acc   = 1'b1;
            res.upd_zero = 1'b1;
        end
        else if (fv.opc == OPC6_AND_FILE)
        begin
            res.result   = acc & fval;
            res.wr_acc   = !fv.dest;
            res.wr_file  = fv.dest;
            res.upd_zero = 1'b1;
        end
        else if (fv.opc == OPC6_COMPL)
        begin
            res.result   = ~fval;
            res.wr_acc   = !fv.dest;
            res.wr_file  = fv.dest;
            res.upd_zero = 1'b1;
        end
        else if (bv.opc == OPC4_SKIP_CLR)
        begin
            res.skip = !fval[bv.bsel];
        end
        else if (bv.opc == OPC4_SKIP_SET)
        begin
            res.skip = fval[bv.bsel];
        end
        else if (cv.opc == OPC3_CALL)
        begin
            res.call = 1'b1;
        end
        else if (instr == INSTR_CLR_WD)
        begin
            res.clr_wd = 1'b1;
        end
        res.zero = (res.result == BYTE_ZERO);
    end

endmodule

// ---- design/exec_subset_core.sv ----
// The AHB-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
// Operation
// - and_literal_op: accumulator and literal, zero only
// - and_file_op: and with file, destination bit
// - skip_if_bit_clear: zero bit discards next instruction
// - skip_if_bit_set: one bit discards next; no flags
// - clear_watchdog_op zeroes counter and prescaler
// - clear_watchdog_op sets timeout and powerdown flags
// - call pushes program counter plus one
// - call loads literal, upper bits from latch
// - call takes two cycles, flags untouched
// - complement_file_op inverts file, destination bit
module exec_subset_core
(
    // clock and reset
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    // ahb-lite slave
    input  wire logic                   hsel,
    input  wire exec_subset_pkg::word_t haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic                   hready,
    input  wire exec_subset_pkg::word_t hwdata,
    output exec_subset_pkg::word_t      hrdata,
    output logic                        hreadyout,
    output logic                        hresp
);
    import exec_subset_pkg::*;

    // every check samples on the bus clock and rests while reset is low
    default clocking assert_clk @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // architectural state
    byte_t               file_mem [FILE_DEPTH];
    pc_t                 stack_mem [STACK_DEPTH];
    byte_t               acc_ff;
    logic                zero_ff;
    logic                timeout_flag_ff;
    logic                powerdown_flag_ff;
    logic                skip_ff;
    pc_t                 pc_ff;
    logic [PCHIGH_W-1:0] pc_high_latch_ff;
    sptr_t               sp_ff;
    byte_t               watchdog_counter_ff;
    byte_t               wd_prescale_ff;
    // sequencing
    exec_state_e         state_ff;
    instr_t              instr_ff;
    // bus side
    logic                pend_ff;
    logic                pwr_ff;
    word_t               paddr_ff;
    word_t               hrdata_ff;
    logic                hreadyout_ff;
    logic                hresp_ff;
    // combinational
    logic                bus_req;
    logic                go;
    logic                bus_wr;
    logic                is_file;
    logic                sel_instr;
    logic                run;
    faddr_t              pidx;
    byte_t               fval;
    byte_t               status_byte;
    pc_t                 ret_addr;
    pc_t                 call_target;
    pc_t                 return_stack_top;
    word_t               rd_word;
    exec_res_s           res;
    file_view_s          fv;
    lit_view_s           lit;
    bit_view_s           bv;
    call_view_s          cv;

    // instruction fields used here
    assign fv  = file_view_s'(instr_ff);
    assign lit = lit_view_s'(instr_ff);
    assign bv  = bit_view_s'(instr_ff);
    assign cv  = call_view_s'(instr_ff);

    // a discarded slot takes the execute cycle and only steps the program counter and clears the skip
    assign run      = (state_ff == ST_EXEC) && !skip_ff;
    assign fval     = file_mem[fv.faddr];
    assign ret_addr = pc_ff + PC_STEP;
    assign call_target = {pc_high_latch_ff[PCHIGH_HI:PCHIGH_LO], cv.k};
    assign return_stack_top = stack_mem[sp_ff - SP_STEP];

    exec_unit exec_unit_inst
    (
        .instr (instr_ff),
        .acc   (acc_ff),
        .fval  (fval),
        .res   (res)
    );

    // bus decode; hsize is not checked, every access is taken as a word
    assign bus_req   = hsel && htrans[HTRANS_ACT_BIT] && hready;
    assign is_file   = (paddr_ff[WORD_W-1:FILE_AW+WORD_LSB]
                        == FILE_BASE[WORD_W-1:FILE_AW+WORD_LSB]);
    assign pidx      = paddr_ff[FILE_AW+WORD_LSB-1:WORD_LSB];
    assign sel_instr = (paddr_ff == OFF_INSTR);
    // an instruction write waits while the previous one still runs
    assign go     = pend_ff && !(pwr_ff && sel_instr && state_ff != ST_IDLE);
    assign bus_wr = go && pwr_ff;

    // status view, unused bits read zero
    always_comb
    begin
        status_byte               = BYTE_ZERO;
        status_byte[SB_ZERO]      = zero_ff;
        status_byte[SB_POWERDOWN] = powerdown_flag_ff;
        status_byte[SB_TIMEOUT]   = timeout_flag_ff;
        status_byte[SB_SKIP]      = skip_ff;
        status_byte[SB_BUSY]      = (state_ff != ST_IDLE);
    end

    // read mux; unmapped addresses answer zero
    always_comb
    begin
        rd_word = '0;
        if (is_file)
        begin
            rd_word = word_t'(file_mem[pidx]);
        end
        else
        begin
            case (paddr_ff)
                OFF_INSTR:    rd_word = word_t'(instr_ff);
                OFF_ACC:      rd_word = word_t'(acc_ff);
                OFF_STATUS:   rd_word = word_t'(status_byte);
                OFF_PC:       rd_word = word_t'(pc_ff);
                OFF_PC_HIGH:  rd_word = word_t'(pc_high_latch_ff);
                OFF_WATCHDOG: rd_word = word_t'({wd_prescale_ff, watchdog_counter_ff});
                OFF_STACK:    rd_word = word_t'({sp_ff, return_stack_top});
                default:      rd_word = '0;
            endcase
        end
    end

    // every access gets at least one wait state so reads never race a write
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pend_ff      <= 1'b0;
            pwr_ff       <= 1'b0;
            paddr_ff     <= '0;
            hreadyout_ff <= 1'b1;
        end
        else if (bus_req)
        begin
            pend_ff      <= 1'b1;
            pwr_ff       <= hwrite;
            paddr_ff     <= haddr;
            hreadyout_ff <= 1'b0;
        end
        else if (go)
        begin
            pend_ff      <= 1'b0;
            hreadyout_ff <= 1'b1;
        end
    end

    // read data and response
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata_ff <= '0;
            hresp_ff  <= HRESP_OKAY;
        end
        else
        begin
            hresp_ff <= HRESP_OKAY;
            if (go && !pwr_ff)
            begin
                hrdata_ff <= rd_word;
            end
        end
    end

    // sequencer: idle, execute, and the extra cycle of a call
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_ff <= ST_IDLE;
            instr_ff <= '0;
        end
        else
        begin
            case (state_ff)
                ST_IDLE:
                begin
                    if (bus_wr && sel_instr)
                    begin
                        instr_ff <= instr_t'(hwdata);
                        state_ff <= ST_EXEC;
                    end
                end
                ST_EXEC:
                begin
                    state_ff <= (run && res.call) ? ST_CALL2 : ST_IDLE;
                end
                ST_CALL2:
                begin
                    state_ff <= ST_IDLE;
                end
                default:
                begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // accumulator; execution wins over a bus write in the same cycle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            acc_ff <= BYTE_ZERO;
        end
        else if (run && res.wr_acc)
        begin
            acc_ff <= res.result;
        end
        else if (bus_wr && paddr_ff == OFF_ACC)
        begin
            acc_ff <= byte_t'(hwdata);
        end
    end

    // zero flag; skips and calls leave it alone
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            zero_ff <= 1'b0;
        end
        else if (run && res.upd_zero)
        begin
            zero_ff <= res.zero;
        end
        else if (bus_wr && paddr_ff == OFF_STATUS)
        begin
            zero_ff <= hwdata[SB_ZERO];
        end
    end

    // timeout and powerdown; the hardware set beats a software write
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            timeout_flag_ff   <= FLAG_RESET;
            powerdown_flag_ff <= FLAG_RESET;
        end
        else if (run && res.clr_wd)
        begin
            timeout_flag_ff   <= 1'b1;
            powerdown_flag_ff <= 1'b1;
        end
        else if (bus_wr && paddr_ff == OFF_STATUS)
        begin
            timeout_flag_ff   <= hwdata[SB_TIMEOUT];
            powerdown_flag_ff <= hwdata[SB_POWERDOWN];
        end
    end

    // skip pending: the next instruction slot becomes a nop
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            skip_ff <= 1'b0;
        end
        else if (state_ff == ST_EXEC)
        begin
            skip_ff <= run && res.skip;
        end
    end

    // program counter steps once per slot, discarded ones included, except that a call loads its target
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pc_ff <= PC_RESET;
        end
        else if (state_ff == ST_EXEC)
        begin
            pc_ff <= (run && res.call) ? call_target : ret_addr;
        end
        else if (bus_wr && paddr_ff == OFF_PC)
        begin
            pc_ff <= pc_t'(hwdata);
        end
    end

    // high latch is written only by software
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pc_high_latch_ff <= PCHIGH_RESET;
        end
        else if (bus_wr && paddr_ff == OFF_PC_HIGH)
        begin
            pc_high_latch_ff <= hwdata[PCHIGH_W-1:0];
        end
    end

    // return stack is circular: a ninth push overwrites the oldest
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sp_ff <= '0;
        end
        else if (run && res.call)
        begin
            sp_ff <= sp_ff + SP_STEP;
        end
    end

    always_ff @(posedge hclk)
    begin
        if (run && res.call)
        begin
            stack_mem[sp_ff] <= ret_addr;
        end
    end

    // file registers; contents are not reset
    always_ff @(posedge hclk)
    begin
        if (run && res.wr_file)
        begin
            file_mem[fv.faddr] <= res.result;
        end
        else if (bus_wr && is_file)
        begin
            file_mem[pidx] <= byte_t'(hwdata);
        end
    end

    // minimal watchdog so the clear has something to act on
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wd_prescale_ff      <= BYTE_ZERO;
            watchdog_counter_ff <= BYTE_ZERO;
        end
        else if (run && res.clr_wd)
        begin
            wd_prescale_ff      <= BYTE_ZERO;
            watchdog_counter_ff <= BYTE_ZERO;
        end
        else
        begin
            wd_prescale_ff <= wd_prescale_ff + BYTE_STEP;
            if (wd_prescale_ff == BYTE_ONES)
            begin
                watchdog_counter_ff <= watchdog_counter_ff + BYTE_STEP;
            end
        end
    end

    assign hrdata    = hrdata_ff;
    assign hreadyout = hreadyout_ff;
    assign hresp     = hresp_ff;

    property p_and_literal;
        (run && lit.opc == OPC6_AND_LIT) |=> acc_ff == ($past(acc_ff) & $past(lit.k));
    endproperty
    a_and_literal: assert property (p_and_literal)
        else $error("and literal result wrong");

    property p_and_file;
        (run && fv.opc == OPC6_AND_FILE && fv.dest)
        |=> (file_mem[$past(fv.faddr)] == ($past(acc_ff) & $past(fval)))
            && $stable(acc_ff);
    endproperty
    a_and_file: assert property (p_and_file)
        else $error("and file result not in file");

    property p_skip_clear;
        (run && bv.opc == OPC4_SKIP_CLR)
        |=> (skip_ff == !$past(fval[bv.bsel])) && $stable(zero_ff);
    endproperty
    a_skip_clear: assert property (p_skip_clear)
        else $error("skip if clear decision wrong");

    property p_skip_set;
        (run && bv.opc == OPC4_SKIP_SET)
        |=> (skip_ff == $past(fval[bv.bsel])) && $stable(zero_ff) && $stable(timeout_flag_ff);
    endproperty
    a_skip_set: assert property (p_skip_set)
        else $error("skip if set decision wrong");

    property p_discard;
        (state_ff == ST_EXEC && skip_ff)
        |=> !skip_ff && $stable(acc_ff) && pc_ff == $past(ret_addr);
    endproperty
    a_discard: assert property (p_discard)
        else $error("discarded slot had an effect");

    property p_wd_clear;
        (run && res.clr_wd) |=> watchdog_counter_ff == BYTE_ZERO ##1 wd_prescale_ff == BYTE_STEP;
    endproperty
    a_wd_clear: assert property (p_wd_clear)
        else $error("watchdog not cleared");

    property p_wd_flags;
        (run && res.clr_wd) |=> timeout_flag_ff && powerdown_flag_ff && $stable(zero_ff);
    endproperty
    a_wd_flags: assert property (p_wd_flags)
        else $error("timeout or powerdown not set");

    property p_call_push;
        (run && res.call) |=> return_stack_top == $past(pc_ff) + PC_STEP;
    endproperty
    a_call_push: assert property (p_call_push)
        else $error("return address wrong");

    property p_call_target;
        (run && res.call)
        |=> pc_ff == {$past(pc_high_latch_ff[PCHIGH_HI:PCHIGH_LO]), $past(cv.k)};
    endproperty
    a_call_target: assert property (p_call_target)
        else $error("call target wrong");

    property p_call_cycles;
        (run && res.call) |=> (state_ff == ST_CALL2 && $stable(zero_ff)) ##1 state_ff == ST_IDLE;
    endproperty
    a_call_cycles: assert property (p_call_cycles)
        else $error("call did not take two cycles");

    property p_complement;
        (run && fv.opc == OPC6_COMPL && !fv.dest) |=> acc_ff == ~$past(fval);
    endproperty
    a_complement: assert property (p_complement)
        else $error("complement result wrong");

    property p_zero;
        (run && res.upd_zero) |=> zero_ff == ($past(res.result) == BYTE_ZERO);
    endproperty
    a_zero: assert property (p_zero)
        else $error("zero flag wrong");

endmodule

// ---- testbench/exec_subset_core_test.sv ----
`timescale 1ns/10ps
module exec_subset_core_test;
    import exec_subset_pkg::*;

    // bus and bench state
    logic       hclk;
    logic       hresetn;
    logic       hsel;
    word_t      haddr;
    logic [1:0] htrans;
    logic       hwrite;
    logic [2:0] hsize;
    word_t      hwdata;
    word_t      hrdata;
    logic       hreadyout;
    logic       hresp;
    int         err_count;
    int         num_checks;
    word_t      rd;
    logic       hit;

    // one slave, so its ready out is the bus ready
    exec_subset_core exec_subset_core_inst
    (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hready    (hreadyout),
        .hwdata    (hwdata),
        .hrdata    (hrdata),
        .hreadyout (hreadyout),
        .hresp     (hresp)
    );

    // 250 mhz clock
    initial
    begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input word_t seen, input word_t exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // bounded wait for ready sampled high; a hung slave ends the run
    task automatic wait_ready();
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 64);
        if (hreadyout !== 1'b1)
        begin
            err_count++;
            results();
        end
    endtask

    // single word transfer; entered just after a rising edge
    task automatic xfer(input word_t a, input logic w, input word_t d, output word_t r);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= w;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        r = hrdata;
        check(word_t'(hresp), word_t'(HRESP_OKAY));
    endtask

    task automatic wr(input word_t a, input word_t d);
        word_t r;
        xfer(a, 1'b1, d, r);
    endtask

    task automatic rd_chk(input word_t a, input word_t exp);
        word_t r;
        xfer(a, 1'b0, '0, r);
        check(r, exp);
    endtask

    // expected status byte from its flags
    function automatic word_t st(input logic z, input logic pd, input logic to, input logic sk);
        st               = '0;
        st[SB_ZERO]      = z;
        st[SB_POWERDOWN] = pd;
        st[SB_TIMEOUT]   = to;
        st[SB_SKIP]      = sk;
    endfunction

    // main sequence; reset held three cycles
    initial
    begin
        hresetn    = 1'b0;
        hsel       = 1'b0;
        haddr      = '0;
        htrans     = 2'b00;
        hwrite     = 1'b0;
        hsize      = 3'h2;
        hwdata     = '0;
        err_count  = 0;
        num_checks = 0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk(OFF_STATUS, st(1'b0, 1'b1, 1'b1, 1'b0));
        rd_chk(OFF_PC, 32'h0000_0000);
        rd_chk(32'h0000_0100, 32'h0000_0000);
        $display("test reset done");
        // literal and: zero result, then all-ones literal
        wr(OFF_STATUS, '0);
        wr(OFF_ACC, 32'h0000_00F0);
        wr(OFF_INSTR, 32'h0000_390F);
        rd_chk(OFF_ACC, 32'h0000_0000);
        rd_chk(OFF_STATUS, st(1'b1, 1'b0, 1'b0, 1'b0));
        wr(OFF_ACC, 32'h0000_003C);
        wr(OFF_INSTR, 32'h0000_39FF);
        rd_chk(OFF_ACC, 32'h0000_003C);
        rd_chk(OFF_STATUS, st(1'b0, 1'b0, 1'b0, 1'b0));
        // file and on the top file address, both destinations
        wr(FILE_BASE + 32'h0000_01FC, 32'h0000_005A);
        wr(OFF_ACC, 32'h0000_000F);
        wr(OFF_INSTR, 32'h0000_057F);
        rd_chk(OFF_ACC, 32'h0000_000A);
        rd_chk(FILE_BASE + 32'h0000_01FC, 32'h0000_005A);
        wr(OFF_ACC, 32'h0000_00A0);
        wr(OFF_INSTR, 32'h0000_05FF);
        rd_chk(FILE_BASE + 32'h0000_01FC, 32'h0000_0000);
        rd_chk(OFF_ACC, 32'h0000_00A0);
        rd_chk(OFF_STATUS, st(1'b1, 1'b0, 1'b0, 1'b0));
        // complement to file, then to accumulator
        wr(FILE_BASE, 32'h0000_00FF);
        wr(OFF_INSTR, 32'h0000_0980);
        rd_chk(FILE_BASE, 32'h0000_0000);
        wr(OFF_INSTR, 32'h0000_0900);
        rd_chk(OFF_ACC, 32'h0000_00FF);
        rd_chk(OFF_STATUS, st(1'b0, 1'b0, 1'b0, 1'b0));
        $display("test logic ops done");
        // every bit of file 5 under both tests; next slot is a zeroing and
        wr(FILE_BASE + 32'h0000_0014, 32'h0000_00A5);
        for (int op = 0; op < 2; op++)
            for (int b = 0; b < 8; b++)
            begin
                hit = (op == 0) ? ~rd_bit(b) : rd_bit(b);
                wr(OFF_PC, 32'h0000_0100);
                wr(OFF_STATUS, st(1'b0, 1'b1, 1'b1, 1'b0));
                wr(OFF_INSTR, (op == 0 ? 32'h0000_1805 : 32'h0000_1C05) | (word_t'(b) << 7));
                rd_chk(OFF_STATUS, st(1'b0, 1'b1, 1'b1, hit));
                wr(OFF_ACC, 32'h0000_00FF);
                wr(OFF_INSTR, 32'h0000_3900);
                rd_chk(OFF_ACC, hit ? 32'h0000_00FF : 32'h0000_0000);
                rd_chk(OFF_STATUS, st(~hit, 1'b1, 1'b1, 1'b0));
                rd_chk(OFF_PC, 32'h0000_0102);
            end
        $display("test bit skip done");
        // let the watchdog advance past a prescaler wrap first
        repeat (300) @(posedge hclk);
        wr(OFF_STATUS, st(1'b1, 1'b0, 1'b0, 1'b0));
        wr(OFF_INSTR, 32'h0000_0064);
        xfer(OFF_WATCHDOG, 1'b0, '0, rd);
        check(word_t'(rd[7:0]), 32'h0000_0000);
        check(word_t'(rd[15:8] < 8'h08), 32'h0000_0001);
        rd_chk(OFF_STATUS, st(1'b1, 1'b1, 1'b1, 1'b0));
        $display("test watchdog done");
        // calls at literal extremes; low latch bits must not leak in
        for (int i = 0; i < 2; i++)
        begin
            wr(OFF_PC, i ? 32'h0000_0FFF : 32'h0000_0123);
            wr(OFF_PC_HIGH, i ? 32'h0000_000F : 32'h0000_0010);
            wr(OFF_INSTR, i ? 32'h0000_2000 : 32'h0000_27FF);
            rd_chk(OFF_PC, i ? 32'h0000_0800 : 32'h0000_17FF);
            xfer(OFF_STACK, 1'b0, '0, rd);
            check(word_t'(rd[12:0]), i ? 32'h0000_1000 : 32'h0000_0124);
            rd_chk(OFF_STATUS, st(1'b1, 1'b1, 1'b1, 1'b0));
        end
        // back-to-back: the two-cycle call is over before the second write's data phase, so it takes no wait
        wr(OFF_INSTR, 32'h0000_27FF);
        wr(OFF_INSTR, 32'h0000_3900);
        rd_chk(OFF_PC, 32'h0000_1000);
        rd_chk(OFF_ACC, 32'h0000_0000);
        $display("test call done");
        results();
    end

    // bit b of the pattern held in file 5
    function automatic logic rd_bit(input int b);
        byte_t v;
        v = 8'hA5;
        rd_bit = v[b];
    endfunction
endmodule
